// ---- src/rsi_top.v ----
`timescale 1ns/1ps
`include "rsi_defines.vh"

module rsi_top
#(
  parameter FIFO_DEPTH = `RSI_FIFO_DEPTH,
  parameter FIFO_AW    = `RSI_FIFO_AW
)
(
  // clock and reset
  input  wire               CORE_CLK,
  input  wire               SYS_RST,
  // configuration
  input  wire               RX_ENABLE_BIT,
  input  wire               TX_ENABLE_BIT,
  input  wire [1:0]         BAUD_COARSE_DIV,
  input  wire [3:0]         BAUD_FINE_DIV,
  input  wire               RX_EXT_BITCLK_SEL,
  input  wire               TX_EXT_BITCLK_SEL,
  input  wire               CODING_ENABLE,
  input  wire [2:0]         LINE_CODE_SELECT,
  input  wire [1:0]         START_DETECT_MODE,
  input  wire [2:0]         RX_IRQ_SOURCE_SEL,
  // processor data path
  input  wire [7:0]         TX_DATA_FIELD,
  input  wire               TX_DATA_WR,
  input  wire               RX_DATA_RD,
  input  wire               RX_OVERRUN_CLR,
  output wire [7:0]         RX_DATA_REG,
  output wire [FIFO_AW:0]   RX_FIFO_COUNT,
  output wire [FIFO_AW:0]   TX_FIFO_COUNT,
  output reg                RX_OVERRUN_FLAG,
  // interrupt requests
  output reg                RX_IRQ,
  output reg                TX_IRQ,
  // transceiver pins
  input  wire               RF_RX_DATA,
  input  wire               RF_RX_BITCLK,
  input  wire               RF_PATTERN_DET,
  input  wire               RF_TX_BITCLK,
  output reg                RF_TX_DATA
);

  localparam [FIFO_AW:0] FULL_CNT = FIFO_DEPTH;
  localparam [FIFO_AW:0] NEAR_CNT = FIFO_DEPTH - 1;
  localparam [FIFO_AW:0] ONE_CNT  = 1;

  // transmit symbol for one bit, or for one half of a bit under either Manchester code
  function tx_symbol;
    input       b;
    input       half;
    input       prev;
    input [2:0] code;
    input       cod;
    begin
      if (!cod)
        tx_symbol = b;
      else
        case (code)
          `RSI_CODE_NRZL: tx_symbol = b;
          `RSI_CODE_NRZM: tx_symbol = b ? ~prev : prev;
          `RSI_CODE_MANL: tx_symbol = half ? ~b : b;
          `RSI_CODE_MANS: tx_symbol = half ? (b ? prev : ~prev)
                                           : ~prev;
          default:        tx_symbol = b;
        endcase
    end
  endfunction

  // two symbols per bit under either Manchester code
  function is_manchester;
    input [2:0] code;
    input       cod;
    begin
      is_manchester = cod && (code == `RSI_CODE_MANS ||
                              code == `RSI_CODE_MANL);
    end
  endfunction

  // pin synchronisers
  reg  [3:0] pin_s1;
  reg  [3:0] pin_s2;
  reg  [3:0] pin_d;
  wire [3:0] pin_rise;

  always @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pin_s1 <= `RSI_PIN_ZERO;
      pin_s2 <= `RSI_PIN_ZERO;
      pin_d  <= `RSI_PIN_ZERO;
    end
    else
    begin
      pin_s1 <= {RF_TX_BITCLK, RF_PATTERN_DET, RF_RX_BITCLK, RF_RX_DATA};
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  assign pin_rise = pin_s2 & ~pin_d;

  // baud generator
  wire os_tick;

  rsi_baud u_baud
  (
    .clk     (CORE_CLK),
    .rst     (SYS_RST),
    .coarse  (BAUD_COARSE_DIV),
    .fine    (BAUD_FINE_DIV),
    .os_tick (os_tick)
  );

  // transmit path
  reg  [3:0] tx_phase;
  reg        tx_busy;
  reg  [7:0] tx_shreg;
  reg  [2:0] tx_bitcnt;
  reg        tx_half;
  reg        tx_cod;
  reg  [2:0] tx_code;
  wire [7:0] tx_head;
  wire       tx_tick;
  wire       tx_two;
  wire       tx_end;
  wire       tx_pop;

  assign tx_tick = TX_EXT_BITCLK_SEL ? pin_rise[`RSI_PIN_TXC]
                 : (os_tick && tx_phase == `RSI_OS_LAST);
  assign tx_two  = is_manchester(tx_code, tx_cod);
  assign tx_end  = tx_busy && tx_bitcnt == `RSI_BIT_LAST &&
                   (!tx_two || tx_half);
  // the next byte leaves the fifo on the last symbol of the current one
  assign tx_pop  = TX_ENABLE_BIT && tx_tick && (!tx_busy || tx_end) &&
                   TX_FIFO_COUNT != {(FIFO_AW+1){1'b0}};

  rsi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo
  (
    .clk   (CORE_CLK),
    .rst   (SYS_RST),
    .flush (1'b0),
    .wr    (TX_DATA_WR),
    .wdata (TX_DATA_FIELD),
    .rd    (tx_pop),
    .rdata (tx_head),
    .count (TX_FIFO_COUNT)
  );

  always @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tx_phase   <= `RSI_PHASE_ZERO;
      tx_busy    <= 1'b0;
      tx_shreg   <= `RSI_BYTE_ZERO;
      tx_bitcnt  <= `RSI_BIT_ZERO;
      tx_half    <= 1'b0;
      tx_cod     <= 1'b0;
      tx_code    <= `RSI_CODE_NRZL;
      RF_TX_DATA <= `RSI_IDLE_LEVEL;
      TX_IRQ     <= 1'b0;
    end
    else if (!TX_ENABLE_BIT)
    begin
      tx_phase   <= `RSI_PHASE_ZERO;
      tx_busy    <= 1'b0;
      tx_bitcnt  <= `RSI_BIT_ZERO;
      tx_half    <= 1'b0;
      RF_TX_DATA <= `RSI_IDLE_LEVEL;
      TX_IRQ     <= 1'b0;
    end
    else
    begin
      if (os_tick)
        tx_phase <= tx_phase + `RSI_PHASE_STEP;
      TX_IRQ <= tx_pop && TX_FIFO_COUNT == ONE_CNT && !TX_DATA_WR;
      if (tx_tick && tx_busy)
      begin
        RF_TX_DATA <= tx_symbol(tx_shreg[7], tx_half, RF_TX_DATA,
                                tx_code, tx_cod);
        if (tx_two && !tx_half)
          tx_half <= 1'b1;
        else
        begin
          tx_half   <= 1'b0;
          tx_shreg  <= {tx_shreg[6:0], 1'b0};
          tx_bitcnt <= tx_bitcnt + `RSI_BIT_STEP;
        end
      end
      if (tx_pop)
      begin
        tx_shreg  <= tx_head;
        tx_bitcnt <= `RSI_BIT_ZERO;
        tx_half   <= 1'b0;
        tx_busy   <= 1'b1;
        tx_cod    <= CODING_ENABLE;
        tx_code   <= LINE_CODE_SELECT;
      end
      else if (tx_tick && tx_end)
        tx_busy <= 1'b0;
    end
  end

  // receive path
  reg  [3:0] rx_phase;
  reg  [7:0] rx_shreg;
  reg  [2:0] rx_bitcnt;
  reg        rx_half;
  reg        rx_first;
  reg        rx_last;
  wire       rx_sym;
  wire       rx_sample;
  wire       rx_start;
  wire       rx_push;
  wire       rx_room;
  reg        dec_ok;
  reg        dec_bit;
  reg        dec_viol;
  reg        next_half;
  reg        next_first;

  assign rx_sym    = pin_s2[`RSI_PIN_RXD];
  assign rx_sample = RX_EXT_BITCLK_SEL ? pin_rise[`RSI_PIN_RXC]
                   : (os_tick && rx_phase == `RSI_SAMPLE_PHASE);

  // symbol decoder
  always @*
  begin
    dec_ok     = 1'b0;
    dec_bit    = rx_sym;
    dec_viol   = 1'b0;
    next_half  = rx_half;
    next_first = rx_first;
    if (!CODING_ENABLE)
      dec_ok = 1'b1;
    else
      case (LINE_CODE_SELECT)
        `RSI_CODE_NRZL:
        begin
          dec_ok = 1'b1;
        end
        `RSI_CODE_NRZM:
        begin
          dec_ok  = 1'b1;
          dec_bit = rx_sym ^ rx_last;
        end
        `RSI_CODE_MANL:
        begin
          next_first = rx_sym;
          next_half  = 1'b1;
          if (rx_half && rx_first != rx_sym)
          begin
            dec_ok    = 1'b1;
            dec_bit   = rx_first;
            next_half = 1'b0;
          end
          else if (rx_half)
            dec_viol = 1'b1; // no mid-bit edge; realign on this symbol
        end
        `RSI_CODE_MANS:
        begin
          if (!rx_half)
          begin
            dec_viol   = rx_sym == rx_last; // missing boundary edge
            next_first = rx_sym;
            next_half  = 1'b1;
          end
          else
          begin
            dec_ok    = 1'b1;
            dec_bit   = rx_first == rx_sym;
            next_half = 1'b0;
          end
        end
        default:
        begin
          dec_ok = 1'b1;
        end
      endcase
  end

  assign rx_start = RX_ENABLE_BIT && (
      (rx_sample && dec_viol &&
       START_DETECT_MODE == `RSI_START_VIOL) ||
      (pin_rise[`RSI_PIN_PAT] &&
       START_DETECT_MODE == `RSI_START_EXT));
  assign rx_push  = RX_ENABLE_BIT && rx_sample && dec_ok &&
                    rx_bitcnt == `RSI_BIT_LAST && !rx_start;
  assign rx_room  = RX_FIFO_COUNT != FULL_CNT || RX_DATA_RD;

  rsi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo
  (
    .clk   (CORE_CLK),
    .rst   (SYS_RST),
    .flush (rx_start),
    .wr    (rx_push),
    .wdata ({rx_shreg[6:0], dec_bit}),
    .rd    (RX_DATA_RD),
    .rdata (RX_DATA_REG),
    .count (RX_FIFO_COUNT)
  );

  always @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rx_phase        <= `RSI_PHASE_ZERO;
      rx_shreg        <= `RSI_BYTE_ZERO;
      rx_bitcnt       <= `RSI_BIT_ZERO;
      rx_half         <= 1'b0;
      rx_first        <= 1'b0;
      rx_last         <= 1'b0;
      RX_IRQ          <= 1'b0;
      RX_OVERRUN_FLAG <= 1'b0;
    end
    else
    begin
      // set wins over a clear in the same cycle
      if (rx_push && !rx_room)
        RX_OVERRUN_FLAG <= 1'b1;
      else if (RX_OVERRUN_CLR)
        RX_OVERRUN_FLAG <= 1'b0;
      if (!RX_ENABLE_BIT)
      begin
        rx_phase  <= `RSI_PHASE_ZERO;
        rx_bitcnt <= `RSI_BIT_ZERO;
        rx_half   <= 1'b0;
        RX_IRQ    <= 1'b0;
      end
      else
      begin
        // phase realigns on every line edge
        if (rx_sym != pin_d[`RSI_PIN_RXD])
          rx_phase <= `RSI_PHASE_ZERO;
        else if (os_tick)
          rx_phase <= rx_phase + `RSI_PHASE_STEP;
        RX_IRQ <= (RX_IRQ_SOURCE_SEL == `RSI_IRQ_START && rx_start) ||
                  (RX_IRQ_SOURCE_SEL == `RSI_IRQ_FULL && rx_push &&
                   RX_FIFO_COUNT == NEAR_CNT && !RX_DATA_RD);
        if (rx_sample)
        begin
          rx_last  <= rx_sym;
          rx_half  <= next_half;
          rx_first <= next_first;
          if (dec_ok)
          begin
            rx_shreg  <= {rx_shreg[6:0], dec_bit};
            rx_bitcnt <= rx_bitcnt + `RSI_BIT_STEP;
          end
        end
        if (rx_start)
          rx_bitcnt <= `RSI_BIT_ZERO;
      end
    end
  end

endmodule // rsi_top

// ---- src/rsi_defines.vh ----
`ifndef RSI_DEFINES_VH
`define RSI_DEFINES_VH

// line coding select codes
`define RSI_CODE_NRZL      3'h0
`define RSI_CODE_NRZM      3'h1
`define RSI_CODE_MANS      3'h2
`define RSI_CODE_MANL      3'h3

// start detection modes
`define RSI_START_VIOL     2'h1
`define RSI_START_EXT      2'h2

// receive interrupt sources
`define RSI_IRQ_START      3'h1
`define RSI_IRQ_FULL       3'h4

// oversampling: sixteen ticks per symbol
`define RSI_OS_LAST        4'hF
`define RSI_SAMPLE_PHASE   4'h7
`define RSI_PHASE_ZERO     4'h0
`define RSI_PHASE_STEP     4'h1

// byte framing
`define RSI_BIT_LAST       3'h7
`define RSI_BIT_ZERO       3'h0
`define RSI_BIT_STEP       3'h1
`define RSI_BYTE_ZERO      8'h00

// fifo and divider
`define RSI_FIFO_DEPTH     4
`define RSI_FIFO_AW        2
`define RSI_FINE_OFFSET    8'h01
`define RSI_DIV_ZERO       8'h00
`define RSI_DIV_STEP       8'h01

// transmit line rest level
`define RSI_IDLE_LEVEL     1'b0

// synchroniser slots for the transceiver pins
`define RSI_PIN_RXD        0
`define RSI_PIN_RXC        1
`define RSI_PIN_PAT        2
`define RSI_PIN_TXC        3
`define RSI_PIN_ZERO       4'h0

`endif

// ---- src/rsi_baud.v ----
`timescale 1ns/1ps
`include "rsi_defines.vh"

module rsi_baud
(
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // division factors
  input  wire [1:0] coarse,
  input  wire [3:0] fine,
  // one pulse per oversample period
  output reg        os_tick
);

  reg  [7:0] cnt;
  wire [7:0] fine_factor;
  wire [7:0] div_last;

  assign fine_factor = {4'h0, fine} + `RSI_FINE_OFFSET;
  // coarse weight is a power of two; code zero gives one
  assign div_last = (fine_factor << coarse) - `RSI_DIV_STEP;

  // >= so a smaller divisor written mid-count takes effect at once
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt     <= `RSI_DIV_ZERO;
      os_tick <= 1'b0;
    end
    else if (cnt >= div_last)
    begin
      cnt     <= `RSI_DIV_ZERO;
      os_tick <= 1'b1;
    end
    else
    begin
      cnt     <= cnt + `RSI_DIV_STEP;
      os_tick <= 1'b0;
    end
  end

endmodule // rsi_baud

// ---- src/rsi_fifo.v ----
`timescale 1ns/1ps
`include "rsi_defines.vh"

module rsi_fifo
#(
  parameter WIDTH = 8,
  parameter DEPTH = `RSI_FIFO_DEPTH,
  parameter AW    = `RSI_FIFO_AW
)
(
  // clock and reset
  input  wire           clk,
  input  wire           rst,
  // control
  input  wire           flush,
  input  wire           wr,
  input  wire [WIDTH-1:0] wdata,
  input  wire           rd,
  // head of queue, registered
  output reg  [WIDTH-1:0] rdata,
  output reg  [AW:0]      count
);

  localparam [AW:0] FULL_CNT = DEPTH;
  localparam [AW:0] ONE_CNT  = 1;
  localparam [AW-1:0] ONE_PTR = 1;

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wptr;
  reg  [AW-1:0]    rptr;
  wire             do_rd;
  wire             do_wr;
  wire [AW-1:0]    rptr_n;

  assign do_rd  = rd & (count != {(AW+1){1'b0}}) & ~flush;
  assign do_wr  = wr & ((count != FULL_CNT) | do_rd) & ~flush;
  assign rptr_n = do_rd ? rptr + ONE_PTR : rptr;

  always @(posedge clk)
  begin
    if (do_wr)
      mem[wptr] <= wdata;
  end

  // head is prefetched so a read returns data with no bubble
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wptr  <= {AW{1'b0}};
      rptr  <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      rdata <= {WIDTH{1'b0}};
    end
    else if (flush)
    begin
      wptr  <= {AW{1'b0}};
      rptr  <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wptr <= wptr + ONE_PTR;
      rptr <= rptr_n;
      if (do_wr & ~do_rd)
        count <= count + ONE_CNT;
      else if (do_rd & ~do_wr)
        count <= count - ONE_CNT;
      rdata <= (do_wr && wptr == rptr_n) ? wdata : mem[rptr_n];
    end
  end

endmodule // rsi_fifo

// ---- testbench/rsi_props.sv ----
`timescale 1ns/1ps
`include "rsi_defines.vh"

module rsi_props
#(
  parameter FIFO_AW = 2
)
(
  // clock and reset
  input wire logic             CORE_CLK,
  input wire logic             SYS_RST,
  // configuration and strobes
  input wire logic             RX_ENABLE_BIT,
  input wire logic             TX_ENABLE_BIT,
  input wire logic [2:0]       RX_IRQ_SOURCE_SEL,
  input wire logic             TX_DATA_WR,
  input wire logic             RX_OVERRUN_CLR,
  // status and line
  input wire logic [FIFO_AW:0] RX_FIFO_COUNT,
  input wire logic [FIFO_AW:0] TX_FIFO_COUNT,
  input wire logic             RX_OVERRUN_FLAG,
  input wire logic             RX_IRQ,
  input wire logic             TX_IRQ,
  input wire logic             RF_TX_DATA
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  // one cycle of grace after disable: the line is registered
  a_tx_line_rest:
    assert property (!TX_ENABLE_BIT && !$past(TX_ENABLE_BIT) |-> !RF_TX_DATA)
    else $error("tx line active while disabled");
  a_rx_quiet_off:
    assert property (!RX_ENABLE_BIT && !$past(RX_ENABLE_BIT) |-> !RX_IRQ)
    else $error("rx irq while receiver disabled");
  a_fifo_depth_bound:
    assert property (RX_FIFO_COUNT <= 4 && TX_FIFO_COUNT <= 4)
    else $error("fifo count above four");
  a_tx_fill_cause:
    assert property (!TX_DATA_WR |=> TX_FIFO_COUNT <= $past(TX_FIFO_COUNT))
    else $error("tx count grew without a write");
  a_tx_irq_empty:
    assert property (TX_IRQ |-> TX_FIFO_COUNT == 0 ##1 !TX_IRQ)
    else $error("tx irq without empty fifo");
  a_full_irq_count:
    assert property (RX_IRQ && $past(RX_IRQ_SOURCE_SEL) == `RSI_IRQ_FULL
      |-> RX_FIFO_COUNT == 4)
    else $error("full irq with fifo not full");
  a_start_irq_flush:
    assert property (RX_IRQ && $past(RX_IRQ_SOURCE_SEL) == `RSI_IRQ_START
      |-> RX_FIFO_COUNT == 0)
    else $error("start irq without flushed fifo");
  a_irq_source_sel:
    assert property (RX_IRQ |-> $past(RX_IRQ_SOURCE_SEL)
      inside {`RSI_IRQ_START, `RSI_IRQ_FULL})
    else $error("rx irq from unselected source");
  a_overrun_hold:
    assert property (RX_OVERRUN_FLAG && !RX_OVERRUN_CLR |=> RX_OVERRUN_FLAG)
    else $error("overrun flag dropped without clear");
  a_overrun_cause:
    assert property ($rose(RX_OVERRUN_FLAG) |-> $past(RX_FIFO_COUNT) == 4)
    else $error("overrun set with room in fifo");
endmodule // rsi_props

bind rsi_top rsi_props #(.FIFO_AW(FIFO_AW)) rsi_props_inst
(
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .RX_ENABLE_BIT(RX_ENABLE_BIT),
  .TX_ENABLE_BIT(TX_ENABLE_BIT), .RX_IRQ_SOURCE_SEL(RX_IRQ_SOURCE_SEL),
  .TX_DATA_WR(TX_DATA_WR), .RX_OVERRUN_CLR(RX_OVERRUN_CLR),
  .RX_FIFO_COUNT(RX_FIFO_COUNT), .TX_FIFO_COUNT(TX_FIFO_COUNT),
  .RX_OVERRUN_FLAG(RX_OVERRUN_FLAG), .RX_IRQ(RX_IRQ), .TX_IRQ(TX_IRQ),
  .RF_TX_DATA(RF_TX_DATA)
);

// ---- testbench/rsi_radio_model.sv ----
`timescale 1ns/1ps

module rsi_radio_model
(
  // receive side toward the block
  output logic rf_rxd,
  output logic rf_rxc,
  output logic rf_pat,
  // transmit bit clock, held still
  output logic rf_txc
);
  logic level;

  initial
  begin
    level = 1'b0;
    {rf_rxd, rf_rxc, rf_pat, rf_txc} = 4'h0;
  end

  // bit clock stands still between frames; data leads the rise by 80 ns
  task automatic send_byte(input logic [7:0] v, input logic mark);
    integer i;
    for (i = 7; i >= 0; i--)
    begin
      level = mark ? level ^ v[i] : v[i];
      rf_rxd = level;
      #80 rf_rxc = 1'b1;
      #80 rf_rxc = 1'b0;
    end
    // released line must not pass for a held bit
    rf_rxd = ~level;
  endtask

  task automatic set_pattern(input logic v);
    rf_pat = v;
  endtask
endmodule // rsi_radio_model

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`include "rsi_defines.vh"

module tb;
  logic       clk, rst, rx_en, tx_en, rx_ext, tx_ext, cod_en, line;
  logic       tx_wr, rx_rd, ovr_clr, ovr, rx_irq, tx_irq;
  logic       rf_rxd, rf_rxc, rf_pat, rf_txc, rf_txd;
  logic [1:0] coarse, start_mode;
  logic [3:0] fine;
  logic [2:0] code, irq_src, rx_cnt, tx_cnt;
  logic [7:0] tx_data, rx_data, b;
  logic       sym_q[$];
  logic [7:0] exp_q[$];
  integer     miscompares, samples_checked, seed, per, i, k;

  rsi_top rsi_top_inst
  (
    .CORE_CLK(clk), .SYS_RST(rst), .RX_ENABLE_BIT(rx_en),
    .TX_ENABLE_BIT(tx_en), .BAUD_COARSE_DIV(coarse), .BAUD_FINE_DIV(fine),
    .RX_EXT_BITCLK_SEL(rx_ext), .TX_EXT_BITCLK_SEL(tx_ext),
    .CODING_ENABLE(cod_en), .LINE_CODE_SELECT(code),
    .START_DETECT_MODE(start_mode), .RX_IRQ_SOURCE_SEL(irq_src),
    .TX_DATA_FIELD(tx_data), .TX_DATA_WR(tx_wr), .RX_DATA_RD(rx_rd),
    .RX_OVERRUN_CLR(ovr_clr), .RX_DATA_REG(rx_data), .RX_FIFO_COUNT(rx_cnt),
    .TX_FIFO_COUNT(tx_cnt), .RX_OVERRUN_FLAG(ovr), .RX_IRQ(rx_irq),
    .TX_IRQ(tx_irq), .RF_RX_DATA(rf_rxd), .RF_RX_BITCLK(rf_rxc),
    .RF_PATTERN_DET(rf_pat), .RF_TX_BITCLK(rf_txc), .RF_TX_DATA(rf_txd)
  );

  rsi_radio_model rsi_radio_model_inst
  (
    .rf_rxd(rf_rxd), .rf_rxc(rf_rxc), .rf_pat(rf_pat), .rf_txc(rf_txc)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // extra cycle after the strobe drops keeps back-to-back calls clean
  task automatic wr(input logic [7:0] v);
    tx_data = v;
    tx_wr = 1'b1;
    step(1);
    tx_wr = 1'b0;
    step(1);
  endtask

  task automatic put(input logic v);
    line = v;
    sym_q.push_back(v);
  endtask

  task automatic encode(input logic [7:0] v, input logic on);
    integer j;
    for (j = 7; j >= 0; j--)
      if (!on || code == `RSI_CODE_NRZL) put(v[j]);
      else if (code == `RSI_CODE_NRZM) put(line ^ v[j]);
      else if (code == `RSI_CODE_MANL)
      begin
        put(v[j]);
        put(!v[j]);
      end
      else
      begin
        put(!line);
        put(v[j] ? line : !line);
      end
  endtask

  // every frame starts with a high symbol, so the first rise marks phase
  task automatic grab(input integer n);
    for (k = 0; k < 9000 && rf_txd !== 1'b1; k++) step(1);
    step(per / 2);
    repeat (n)
    begin
      b = {7'h00, sym_q.pop_front()};
      check("tx symbol", {7'h00, rf_txd}, b);
      step(per);
    end
  endtask

  initial
  begin
    seed = 25;
    miscompares = 0;
    samples_checked = 0;
    {rst, rx_en, tx_en, rx_ext, tx_ext, cod_en, line} = 7'h40;
    {tx_wr, rx_rd, ovr_clr, coarse, start_mode, fine} = 11'h000;
    {code, irq_src, tx_data} = 14'h0000;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    fine = {2'h0, 2'($random(seed))};
    coarse = {1'b0, 1'($random(seed))};
    per = 16 * (fine + 1) * (1 << coarse);
    cod_en = 1'b1;
    for (i = 0; i < 5; i++) wr(i < 3 ? 8'hAA : (i == 3 ? 8'hD4 : 8'h55));
    for (i = 0; i < 4; i++) encode(i < 3 ? 8'hAA : 8'hD4, 1'b1);
    check("tx count", {5'h00, tx_cnt}, 8'h04);
    check("idle line", {7'h00, rf_txd}, 8'h00);
    tx_en = 1'b1;
    grab(32);
    tx_en = 1'b0;
    step(2);
    for (i = 0; i < 4; i++)
    begin
      code = 3'(i);
      line = 1'b0;
      b = 8'($random(seed));
      wr(8'hD4);
      wr(b);
      encode(8'hD4, 1'b1);
      encode(b, 1'b1);
      tx_en = 1'b1;
      grab(i < 2 ? 16 : 32);
      tx_en = 1'b0;
      step(2);
    end
    code = `RSI_CODE_MANS;
    cod_en = 1'b0;
    wr(8'h00);
    tx_en = 1'b1;
    for (k = 0; k < 3000 && tx_irq !== 1'b1; k++) step(1);
    check("tx irq", {7'h00, tx_irq}, 8'h01);
    cod_en = 1'b1;
    wr(8'hD4);
    line = 1'b0;
    encode(8'hD4, 1'b1);
    grab(16);
    tx_en = 1'b0;
    {rx_en, rx_ext} = 2'h3;
    code = `RSI_CODE_NRZL;
    start_mode = `RSI_START_EXT;
    irq_src = `RSI_IRQ_START;
    // bytes before the start marker are unsynchronised and get discarded
    for (i = 0; i < 2; i++)
      rsi_radio_model_inst.send_byte(8'($random(seed)), 1'b0);
    rsi_radio_model_inst.set_pattern(1'b1);
    for (k = 0; k < 100 && rx_irq !== 1'b1; k++) step(1);
    check("start irq", {7'h00, rx_irq}, 8'h01);
    check("rx count", {5'h00, rx_cnt}, 8'h00);
    rsi_radio_model_inst.set_pattern(1'b0);
    irq_src = `RSI_IRQ_FULL;
    for (i = 0; i < 5; i++)
    begin
      b = 8'($random(seed));
      if (i < 4) exp_q.push_back(b);
      rsi_radio_model_inst.send_byte(b, 1'b0);
    end
    step(6);
    check("rx count", {5'h00, rx_cnt}, 8'h04);
    check("overrun", {7'h00, ovr}, 8'h01);
    for (i = 0; i < 4; i++)
    begin
      check("rx byte", rx_data, exp_q.pop_front());
      rx_rd = 1'b1;
      step(1);
      rx_rd = 1'b0;
      step(1);
    end
    check("rx count", {5'h00, rx_cnt}, 8'h00);
    ovr_clr = 1'b1;
    step(1);
    ovr_clr = 1'b0;
    check("overrun", {7'h00, ovr}, 8'h00);
    code = `RSI_CODE_NRZM;
    b = 8'($random(seed));
    rsi_radio_model_inst.send_byte(b, 1'b1);
    step(6);
    check("mark byte", rx_data, b);
    rx_en = 1'b0;
    rsi_radio_model_inst.send_byte(8'hC3, 1'b0);
    step(6);
    check("rx count", {5'h00, rx_cnt}, 8'h01);
    // two equal halves under level coding are a violation: start, flush
    code = `RSI_CODE_MANL;
    start_mode = `RSI_START_VIOL;
    irq_src = `RSI_IRQ_START;
    rx_en = 1'b1;
    rsi_radio_model_inst.send_byte(8'h00, 1'b0);
    step(6);
    check("rx count", {5'h00, rx_cnt}, 8'h00);
    wrap_up;
  end

  initial
  begin
    #1_500_000;
    miscompares++;
    wrap_up;
  end
endmodule // tb
